// [core/smcd_defines.svh]
// constants for the sector map configuration detect block
`ifndef SMCD_DEFINES_SVH
`define SMCD_DEFINES_SVH
`define SMCD_ERASE_T4 8'hff
`define SMCD_ERASE_T3 8'hdc
`define SMCD_ERASE_T2 8'hdc
`define SMCD_ERASE_T1 8'h21
`define SMCD_TABLE_BASE 8'h44
`define SMCD_TABLE_LEN 8'h10
`define SMCD_DETECT_CMD 8'h65
`define SMCD_DESC_LOW 8'hfc
`define SMCD_DESC_LAT 8'hff
`define SMCD_ARCH_MASK 8'h08
`define SMCD_LOC_MASK 8'h04
`define SMCD_ARCH_ADDR 32'h0000_0004
`define SMCD_IDX_BOTTOM 8'h01
`define SMCD_IDX_TOP 8'h03
`define SMCD_IDX_UNIFORM 8'h05
`define SMCD_IDX_INVALID 8'hff
`endif

// [core/smcd_pkg.sv]
// types for the sector map configuration detect block
package smcd_pkg;
    typedef enum logic [1:0] {
        SMCD_MAP_BOTTOM = 2'h0,
        SMCD_MAP_TOP = 2'h1,
        SMCD_MAP_UNIFORM = 2'h3,
        SMCD_MAP_INVALID = 2'h2
    } smcd_map_type;
endpackage : smcd_pkg

// [core/smcd_top.sv]
// sector map detect: table bytes and map index
`include "smcd_defines.svh"
module smcd_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] rd_addr,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [7:0] wr_data,
    input wire logic nv_config_reg_three_bit3,
    input wire logic nv_config_reg_one_bit2,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [31:0] erase_word,
    output logic [7:0] map_index,
    output smcd_pkg::smcd_map_type map_sel
);
    logic [1:0] cfg_pin;
    logic [1:0] cfg_sync;
    logic arch_sync;
    logic loc_sync;
    logic [7:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic [31:0] erase_reg, erase_next;
    logic [7:0] idx_reg, idx_next;
    smcd_pkg::smcd_map_type map_reg, map_next;
    logic [7:0] offs;

    assign cfg_pin = {nv_config_reg_three_bit3, nv_config_reg_one_bit2};

    // two flip-flops per configuration pin before any logic reads it
    for (genvar g = 0; g < 2; g++) begin : gen_sync
        logic s1_reg, s1_next;
        logic s2_reg, s2_next;

        always_comb begin
            s1_next = cfg_pin[g];
            s2_next = s1_reg;
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
            end else begin
                s1_reg <= s1_next;
                s2_reg <= s2_next;
            end
        end

        assign cfg_sync[g] = s2_reg;
    end : gen_sync

    assign arch_sync = cfg_sync[1];
    assign loc_sync = cfg_sync[0];

    // table read port: one byte per request, writes never reach it
    always_comb begin
        offs = rd_addr - `SMCD_TABLE_BASE;
        rd_valid_next = rd_req;
        rd_data_next = rd_data_reg;
        if (rd_req) begin
            unique case (offs)
                8'h00: rd_data_next = `SMCD_ERASE_T1;
                8'h01: rd_data_next = `SMCD_ERASE_T2;
                8'h02: rd_data_next = `SMCD_ERASE_T3;
                8'h03: rd_data_next = `SMCD_ERASE_T4;
                8'h04: rd_data_next = `SMCD_DESC_LOW;
                8'h05: rd_data_next = `SMCD_DETECT_CMD;
                8'h06: rd_data_next = `SMCD_DESC_LAT;
                8'h07: rd_data_next = `SMCD_ARCH_MASK;
                8'h08: rd_data_next = 8'(`SMCD_ARCH_ADDR);
                8'h0c: rd_data_next = `SMCD_DESC_LOW;
                8'h0d: rd_data_next = `SMCD_DETECT_CMD;
                8'h0e: rd_data_next = `SMCD_DESC_LAT;
                8'h0f: rd_data_next = `SMCD_LOC_MASK;
                default: rd_data_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // erase opcode word, one byte per erase type
    always_comb begin
        erase_next = {`SMCD_ERASE_T4,
                      `SMCD_ERASE_T3,
                      `SMCD_ERASE_T2,
                      `SMCD_ERASE_T1};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            erase_reg <= 32'h0000_0000;
        end else begin
            erase_reg <= erase_next;
        end
    end

    // map index from the synchronised bits, architecture bit first
    always_comb begin
        unique case ({arch_sync, loc_sync})
            2'b00: begin
                idx_next = `SMCD_IDX_BOTTOM;
                map_next = smcd_pkg::SMCD_MAP_BOTTOM;
            end
            2'b01: begin
                idx_next = `SMCD_IDX_TOP;
                map_next = smcd_pkg::SMCD_MAP_TOP;
            end
            2'b10: begin
                idx_next = `SMCD_IDX_UNIFORM;
                map_next = smcd_pkg::SMCD_MAP_UNIFORM;
            end
            default: begin
                idx_next = `SMCD_IDX_INVALID;
                map_next = smcd_pkg::SMCD_MAP_INVALID;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            idx_reg <= `SMCD_IDX_BOTTOM;
            map_reg <= smcd_pkg::SMCD_MAP_BOTTOM;
        end else begin
            idx_reg <= idx_next;
            map_reg <= map_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign erase_word = erase_reg;
    assign map_index = idx_reg;
    assign map_sel = map_reg;

    erase_word_a: assert property (
        @(posedge clk) disable iff (srst)
        $past(!srst) |-> erase_word == 32'hffdc_dc21)
        else $error("erase word wrong");

    erase_steady_a: assert property (
        @(posedge clk) disable iff (srst)
        $past(!srst, 2) |-> $stable(erase_word))
        else $error("erase word changed");

    erase_byte_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req && rd_addr == 8'h47 |=> rd_data == 8'hff)
        else $error("erase type 4 byte wrong");

    erase_high_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req && rd_addr == 8'h46 |=> rd_data == 8'hdc)
        else $error("erase type 3 byte wrong");

    erase_low_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req && rd_addr == 8'h44 |=> rd_data == 8'h21)
        else $error("erase type 1 byte wrong");

    erase_mid_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req && rd_addr == 8'h45 |=> rd_data == 8'hdc)
        else $error("erase type 2 byte wrong");

    read_only_a: assert property (
        @(posedge clk) disable iff (srst)
        wr_req && !rd_req |=> $stable(rd_data))
        else $error("write changed table");

    table_write_a: assert property (
        @(posedge clk) disable iff (srst)
        wr_req && !rd_req && wr_data != rd_data
            |=> rd_data != $past(wr_data))
        else $error("write data reached table");

    read_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        !rd_req |=> $stable(rd_data))
        else $error("read byte changed without request");

    unmapped_zero_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req && (rd_addr < 8'h44 || rd_addr > 8'h53)
            |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    valid_pulse_a: assert property (
        @(posedge clk) disable iff (srst)
        rd_req |=> rd_valid)
        else $error("read not answered");

    valid_drop_a: assert property (
        @(posedge clk) disable iff (srst)
        !rd_req |=> !rd_valid)
        else $error("answer without request");

    sync_delay_a: assert property (
        @(posedge clk) disable iff (srst)
        $past(!srst) && $past(!srst, 2) |-> cfg_sync == $past(cfg_pin, 2))
        else $error("configuration sync delay wrong");

    index_uniform_a: assert property (
        @(posedge clk) disable iff (srst)
        arch_sync && !loc_sync |=> map_index == 8'h05
            && map_sel == smcd_pkg::SMCD_MAP_UNIFORM)
        else $error("uniform index wrong");

    index_top_a: assert property (
        @(posedge clk) disable iff (srst)
        !arch_sync && loc_sync |=> map_index == 8'h03
            && map_sel == smcd_pkg::SMCD_MAP_TOP)
        else $error("top index wrong");

    index_bottom_a: assert property (
        @(posedge clk) disable iff (srst)
        !arch_sync && !loc_sync |=> map_index == 8'h01
            && map_sel == smcd_pkg::SMCD_MAP_BOTTOM)
        else $error("bottom index wrong");

    index_invalid_a: assert property (
        @(posedge clk) disable iff (srst)
        arch_sync && loc_sync |=> map_index == 8'hff
            && map_sel == smcd_pkg::SMCD_MAP_INVALID)
        else $error("invalid index wrong");
endmodule : smcd_top

// [dv/smcd_host_model.sv]
// host side model: register bytes and the index the host forms from them
module smcd_host_model (
    input wire logic [1:0] combo,
    output logic arch_bit,
    output logic loc_bit,
    output logic [7:0] exp_index
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] arch_mask = 8'h08;
    localparam logic [7:0] loc_mask = 8'h04;
    logic [7:0] reg_three_byte;
    logic [7:0] reg_one_byte;
    // bytes as a read-any-register access returns them, other bits a fixed mix of ones and zeros
    assign reg_three_byte = {4'ha, combo[1], 3'h5};
    assign reg_one_byte = {5'h15, combo[0], 2'h1};
    assign arch_bit = |(reg_three_byte & arch_mask);
    assign loc_bit = |(reg_one_byte & loc_mask);
    // only the three listed combinations unless a scenario asks for 11
    assign exp_index = (arch_bit && loc_bit) ? 8'hff
        : {5'h00, arch_bit, loc_bit, 1'b1};
endmodule : smcd_host_model

// [dv/smcd_top_test.sv]
// testbench for the sector map detect block
module smcd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, rd_req = 1'b0, wr_req = 1'b0;
    logic [7:0] rd_addr = 8'h00, wr_data = 8'h00, rd_data, map_index;
    logic [1:0] combo = 2'h0;
    logic arch_bit, loc_bit, rd_valid;
    logic [7:0] exp_index;
    logic [31:0] erase_word;
    smcd_pkg::smcd_map_type map_sel;
    int failures = 0, tests_run = 0;
    initial forever #5 clk = ~clk;
    smcd_host_model smcd_host_model_inst (.combo(combo), .arch_bit(arch_bit),
        .loc_bit(loc_bit), .exp_index(exp_index));
    smcd_top smcd_top_inst (.clk(clk), .srst(srst), .rd_addr(rd_addr),
        .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data),
        .nv_config_reg_three_bit3(arch_bit), .nv_config_reg_one_bit2(loc_bit),
        .rd_data(rd_data), .rd_valid(rd_valid), .erase_word(erase_word),
        .map_index(map_index), .map_sel(map_sel));
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        rd_addr = a;
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            failures++;
            end_sim();
        end
        chk(rd_data, exp);
        @(negedge clk);
        chk(rd_valid, 1'b0);
    endtask : rd
    task test_erase;
        logic [7:0] b [4];
        b = '{8'h21, 8'hdc, 8'hdc, 8'hff};
        chk(erase_word, 32'hffdcdc21);
        for (int i = 0; i < 4; i++) begin
            rd(8'h44 + 8'(i), b[i]);
        end
        rd(8'h20, 8'h00);
    endtask : test_erase
    task test_write;
        rd_addr = 8'h45;
        wr_data = 8'h5a;
        wr_req = 1'b1;
        @(negedge clk);
        wr_req = 1'b0;
        chk(rd_data, 8'h00);
        chk(rd_valid, 1'b0);
        rd(8'h45, 8'hdc);
        chk(erase_word, 32'hffdcdc21);
    endtask : test_write
    task test_map;
        logic [7:0] idx [4];
        logic [1:0] sel [4];
        idx = '{8'h01, 8'h03, 8'h05, 8'hff};
        sel = '{2'h0, 2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 4; i++) begin
            combo = 2'(i);
            repeat (5) @(negedge clk);
            chk(map_index, idx[i]);
            chk(map_sel, sel[i]);
            chk(map_index, exp_index);
        end
    endtask : test_map
    task test_detect;
        rd(8'h48, 8'hfc);
        rd(8'h49, 8'h65);
        rd(8'h4a, 8'hff);
        rd(8'h4b, 8'h08);
        rd(8'h4c, 8'h04);
        rd(8'h4f, 8'h00);
        rd(8'h51, 8'h65);
        rd(8'h53, 8'h04);
    endtask : test_detect
    task test_reset;
        combo = 2'h2;
        repeat (5) @(negedge clk);
        chk(map_index, 8'h05);
        srst = 1'b1;
        @(negedge clk);
        chk(map_index, 8'h01);
        chk(rd_valid, 1'b0);
        repeat (2) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk(erase_word, 32'hffdcdc21);
        repeat (4) @(negedge clk);
        chk(map_index, 8'h05);
        rd(8'h47, 8'hff);
    endtask : test_reset
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        test_erase();
        test_write();
        test_map();
        test_detect();
        test_reset();
        end_sim();
    end
endmodule : smcd_top_test
